// ### design/cpw_regs.vh
// constants for the central cyclic process words of a drive control unit
// assumes 16-bit telegram words exchanged with one fieldbus controller
`ifndef CPW_REGS_VH
`define CPW_REGS_VH

// word geometry
`define CPW_WORD_W 16
`define CPW_REC_DEPTH 8
`define CPW_REC_AW 3
`define CPW_IO_N 4

// control word bits
`define CPW_CW_PING 1
`define CPW_CW_ACK 7
`define CPW_CW_XFER 10

// status word bits
`define CPW_SW_FAULT 3
`define CPW_SW_ALARM 7
`define CPW_SW_TSYNC 8
`define CPW_SW_NOGALM 9
`define CPW_SW_NOGFLT 10
`define CPW_SW_ONE 11

// input word field positions
`define CPW_IW_TERM_LO 0
`define CPW_IW_DIN_LO 8

// output word field position
`define CPW_OW_DO_LO 0

// reset values
`define CPW_WORD_RST 16'h0000
`define CPW_IO_RST 4'h0
`define CPW_ROUTE_RST 2'h0

`endif

// ### design/cpw_sync2.v
// two-flop synchroniser for pin levels
// assumes inputs are slow levels from outside the core clock domain
`timescale 1ns/10ps

module cpw_sync2 #(
    parameter W = 4
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [W-1:0] pin_in,
    output wire [W-1:0] sync_out
);

reg [W-1:0] meta_q;
reg [W-1:0] stab_q;

// first stage feeds only the second
always @(posedge core_clk) begin
    if (sys_rst) begin
        meta_q <= {W{1'b0}};
        stab_q <= {W{1'b0}};
    end else begin
        meta_q <= pin_in;
        stab_q <= meta_q;
    end
end

assign sync_out = stab_q;

endmodule

// ### design/cpw_diag_rec.v
// diagnostic record: keeps active entries and sends them out in order
// assumes depth is a power of two; clear empties it (acknowledge)
`timescale 1ns/10ps

module cpw_diag_rec #(
    parameter W = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire core_clk,
    input wire sys_rst,
    input wire push,
    input wire [W-1:0] push_data,
    input wire clear,
    input wire send,
    output wire pend,
    output wire [W-1:0] send_data,
    output wire occupied,
    output wire full
);

reg [W-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wp_q;
reg [AW-1:0] sp_q;
reg [AW:0] cnt_q;
reg [AW:0] uns_q;
wire do_push;
wire do_send;

assign full = (cnt_q == DEPTH[AW:0]);
assign do_push = push & (~full | clear);
assign do_send = send & (uns_q != {(AW+1){1'b0}});

// entries kept in arrival order, send pointer walks behind
always @(posedge core_clk) begin
    if (do_push) begin
        mem[clear ? {AW{1'b0}} : wp_q] <= push_data;
    end
end

// pointers; a new entry in the clearing cycle survives the clear
always @(posedge core_clk) begin
    if (sys_rst) begin
        wp_q <= {AW{1'b0}};
        sp_q <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
        uns_q <= {(AW+1){1'b0}};
    end else if (clear) begin
        wp_q <= {{(AW-1){1'b0}}, push};
        sp_q <= {AW{1'b0}};
        cnt_q <= {{AW{1'b0}}, push};
        uns_q <= {{AW{1'b0}}, push};
    end else begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, do_push};
        sp_q <= sp_q + {{(AW-1){1'b0}}, do_send};
        cnt_q <= cnt_q + {{AW{1'b0}}, do_push};
        uns_q <= uns_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_send};
    end
end

assign pend = (uns_q != {(AW+1){1'b0}});
assign send_data = mem[sp_q];
assign occupied = (cnt_q != {(AW+1){1'b0}});

endmodule

// ### design/cpw_central_words.v
// central cyclic process words: control, output, status and input words
// plus two diagnostic channels for faults and alarms
// assumes telegram words and events come from logic on core_clk; pins
// and terminal inputs are asynchronous and are synchronised here
`timescale 1ns/10ps
`include "cpw_regs.vh"

module cpw_central_words #(
    parameter W = `CPW_WORD_W,
    parameter DEPTH = `CPW_REC_DEPTH,
    parameter AW = `CPW_REC_AW,
    parameter N = `CPW_IO_N
) (
    input wire core_clk,
    input wire sys_rst,
    input wire rx_stb,
    input wire [W-1:0] rx_ctrl_word,
    input wire [W-1:0] rx_out_word,
    output reg [W-1:0] tx_status_word,
    output reg [W-1:0] tx_input_word,
    input wire [N-1:0] din_pin,
    input wire [N-1:0] term_in,
    output reg [N-1:0] term_out,
    output reg [N-1:0] term_oe,
    input wire [N-1:0] term_dir_cfg,
    output reg [N-1:0] dout_pin,
    output reg utc_set,
    input wire obj_acked,
    input wire time_sync_req,
    input wire flt_evt,
    input wire [W-1:0] flt_code,
    input wire [W-1:0] flt_class,
    input wire alm_evt,
    input wire [W-1:0] alm_code,
    input wire [W-1:0] alm_class,
    input wire alm_gone,
    input wire diag_en_cfg,
    input wire class_mode_cfg,
    input wire [1:0] route_cfg,
    input wire shared_cfg,
    output reg diag_a_one,
    output reg diag_a_two,
    output reg [W-1:0] diag_a_data,
    output reg diag_b_one,
    output reg diag_b_two,
    output reg [W-1:0] diag_b_data,
    output reg flt_lost,
    output reg alm_lost
);

////////////////////////////////////////////////////////////////////////
// received telegram words

reg [W-1:0] ctrl_q;
reg [N-1:0] do_q;
reg ping_prev_q;
reg ack_prev_q;
wire ping_edge;
wire ack_edge;

// between telegrams the last words stand, so bit edges are judged
// against the latched copy and never against the raw bus words
// latch words on each telegram; reserved bits are never used
always @(posedge core_clk) begin
    if (sys_rst) begin
        ctrl_q <= `CPW_WORD_RST;
        do_q <= `CPW_IO_RST;
    end else if (rx_stb) begin
        ctrl_q <= rx_ctrl_word;
        do_q <= rx_out_word[`CPW_OW_DO_LO +: N];
    end
end

// edge history of ping and acknowledge bits
always @(posedge core_clk) begin
    if (sys_rst) begin
        ping_prev_q <= 1'b0;
        ack_prev_q <= 1'b0;
    end else begin
        ping_prev_q <= ctrl_q[`CPW_CW_PING];
        ack_prev_q <= ctrl_q[`CPW_CW_ACK];
    end
end

assign ping_edge = ctrl_q[`CPW_CW_PING] & ~ping_prev_q;
assign ack_edge = ctrl_q[`CPW_CW_ACK] & ~ack_prev_q;

// utc set pulse on each ping event
always @(posedge core_clk) begin
    if (sys_rst) begin
        utc_set <= 1'b0;
    end else begin
        utc_set <= ping_edge;
    end
end

////////////////////////////////////////////////////////////////////////
// pins: outputs, configurable terminals, inputs

wire [N-1:0] din_s;
wire [N-1:0] term_s;

cpw_sync2 #(
    .W(N)
) u_din_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(din_pin),
    .sync_out(din_s)
);

cpw_sync2 #(
    .W(N)
) u_term_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(term_in),
    .sync_out(term_s)
);

// outputs follow the received word directly
always @(posedge core_clk) begin
    if (sys_rst) begin
        dout_pin <= `CPW_IO_RST;
    end else begin
        dout_pin <= do_q;
    end
end

// each terminal is input or output by its direction bit
genvar gi;
generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_term
        always @(posedge core_clk) begin
            if (sys_rst) begin
                term_oe[gi] <= 1'b0;
                term_out[gi] <= 1'b0;
            end else begin
                term_oe[gi] <= term_dir_cfg[gi];
                term_out[gi] <= term_dir_cfg[gi] & do_q[gi];
            end
        end
    end
endgenerate

// input word; every terminal reports its synchronised pin level, whatever its direction
always @(posedge core_clk) begin
    if (sys_rst) begin
        tx_input_word <= `CPW_WORD_RST;
    end else begin
        tx_input_word <= `CPW_WORD_RST;
        tx_input_word[`CPW_IW_TERM_LO +: N] <= term_s;
        tx_input_word[`CPW_IW_DIN_LO +: N] <= din_s;
    end
end

////////////////////////////////////////////////////////////////////////
// power-up configuration of diagnostics

reg diag_en_q;
reg class_mode_q;
reg [1:0] route_q;
reg shared_q;

// changing routing while running could split a message stream, so
// these settings stay frozen until the next reset
// taken only while reset is held, so changes wait for power-up
always @(posedge core_clk) begin
    if (sys_rst) begin
        diag_en_q <= diag_en_cfg;
        class_mode_q <= class_mode_cfg;
        route_q <= route_cfg;
        shared_q <= shared_cfg;
    end
end

////////////////////////////////////////////////////////////////////////
// fault handling and acknowledge

reg unit_flt_q;
wire unit_clr;
wire flt_clear;
wire f_pend;
wire f_occ;
wire f_full;
wire [W-1:0] f_data;
wire [W-1:0] f_push_data;
wire a_pend;
wire a_occ;
wire a_full;
wire [W-1:0] a_data;
wire [W-1:0] a_push_data;
wire send_a;
wire send_b;

// with an outside master in control, object acknowledges alone are
// not enough: the master must also pulse its own acknowledge
// unit fault clears implicitly or needs explicit acknowledge
assign unit_clr = ctrl_q[`CPW_CW_XFER]
    ? (obj_acked & ack_edge)
    : obj_acked;

// acknowledge edge empties the fault record
assign flt_clear = ack_edge;

// unit fault flag; a new fault wins over the clear
always @(posedge core_clk) begin
    if (sys_rst) begin
        unit_flt_q <= 1'b0;
    end else if (flt_evt) begin
        unit_flt_q <= 1'b1;
    end else if (unit_clr) begin
        unit_flt_q <= 1'b0;
    end
end

// message content: vendor code or error class, no timestamp
assign f_push_data = class_mode_q ? flt_class : flt_code;
assign a_push_data = class_mode_q ? alm_class : alm_code;

cpw_diag_rec #(
    .W(W),
    .DEPTH(DEPTH),
    .AW(AW)
) u_flt_rec (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(flt_evt),
    .push_data(f_push_data),
    .clear(flt_clear),
    .send(send_a),
    .pend(f_pend),
    .send_data(f_data),
    .occupied(f_occ),
    .full(f_full)
);

cpw_diag_rec #(
    .W(W),
    .DEPTH(DEPTH),
    .AW(AW)
) u_alm_rec (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(alm_evt),
    .push_data(a_push_data),
    .clear(alm_gone),
    .send(send_b),
    .pend(a_pend),
    .send_data(a_data),
    .occupied(a_occ),
    .full(a_full)
);

// a full record drops the newest event, so the order already
// reported upstream is never rewritten
// sticky overrun flags when a full record drops an event
always @(posedge core_clk) begin
    if (sys_rst) begin
        flt_lost <= 1'b0;
        alm_lost <= 1'b0;
    end else begin
        if (flt_evt & f_full & ~flt_clear) begin
            flt_lost <= 1'b1;
        end else if (flt_clear) begin
            flt_lost <= 1'b0;
        end
        if (alm_evt & a_full & ~alm_gone) begin
            alm_lost <= 1'b1;
        end else if (alm_gone) begin
            alm_lost <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// status word

// the no-fault bit also watches the unit fault, which can outlive an
// emptied record while drive objects are still unacknowledged
// status rebuilt every cycle; reserved bits zero, bit 11 one
always @(posedge core_clk) begin
    if (sys_rst) begin
        tx_status_word <= `CPW_WORD_RST;
    end else begin
        tx_status_word <= `CPW_WORD_RST;
        tx_status_word[`CPW_SW_FAULT] <= f_occ;
        tx_status_word[`CPW_SW_ALARM] <= a_occ;
        tx_status_word[`CPW_SW_TSYNC] <= time_sync_req;
        tx_status_word[`CPW_SW_NOGALM] <= ~a_occ;
        tx_status_word[`CPW_SW_NOGFLT] <= ~(f_occ | unit_flt_q);
        tx_status_word[`CPW_SW_ONE] <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// diagnostic channels: a carries faults, b carries alarms

wire to_one;
wire to_two;

// port selection; shared device limits delivery to one controller
assign to_one = route_q[0];
assign to_two = route_q[1] & ~(shared_q & route_q[0]);

// a disabled channel still lets its record fill, so the status bits
// keep telling the truth even when nothing is forwarded
// each channel sends its oldest unsent entry independently
assign send_a = diag_en_q & f_pend;
assign send_b = diag_en_q & a_pend;

// channel a output registers
always @(posedge core_clk) begin
    if (sys_rst) begin
        diag_a_one <= 1'b0;
        diag_a_two <= 1'b0;
        diag_a_data <= `CPW_WORD_RST;
    end else begin
        diag_a_one <= send_a & to_one;
        diag_a_two <= send_a & to_two;
        if (send_a) begin
            diag_a_data <= f_data;
        end
    end
end

// channel b output registers
always @(posedge core_clk) begin
    if (sys_rst) begin
        diag_b_one <= 1'b0;
        diag_b_two <= 1'b0;
        diag_b_data <= `CPW_WORD_RST;
    end else begin
        diag_b_one <= send_b & to_one;
        diag_b_two <= send_b & to_two;
        if (send_b) begin
            diag_b_data <= a_data;
        end
    end
end

endmodule

// ### sim/cpw_central_words_assertions.sv
// checker for the central words, bound to the top module
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/10ps

module cpw_words_chk #(
    parameter W = 16,
    parameter N = 4
) (
    input logic core_clk,
    input logic sys_rst,
    input logic rx_stb,
    input logic [W-1:0] rx_ctrl_word,
    input logic [W-1:0] rx_out_word,
    input logic [W-1:0] tx_status_word,
    input logic [N-1:0] term_out,
    input logic [N-1:0] term_oe,
    input logic [N-1:0] dout_pin,
    input logic utc_set,
    input logic flt_evt,
    input logic diag_en_cfg,
    input logic [1:0] route_cfg,
    input logic shared_cfg,
    input logic diag_a_one,
    input logic diag_a_two,
    input logic diag_b_two,
    input logic flt_lost
);
    logic up_q;
    logic ping_q;
    logic en_q;
    logic sh_q;
    logic [1:0] rt_q;

    // out-of-reset flag, last latched ping bit, power-up configuration
    always_ff @(posedge core_clk) begin
        up_q <= !sys_rst;
        if (sys_rst) begin
            ping_q <= 1'b0;
            en_q <= diag_en_cfg;
            sh_q <= shared_cfg;
            rt_q <= route_cfg;
        end else if (rx_stb) begin
            ping_q <= rx_ctrl_word[1];
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////
    // ping edge gives one pulse two edges on
    sequence s_ping;
        rx_stb && rx_ctrl_word[1] && !ping_q;
    endsequence
    sequence s_pulse;
        utc_set ##1 !utc_set;
    endsequence
    property p_ping;
        s_ping |-> ##2 s_pulse;
    endproperty
    a_ping: assert property (p_ping) else $error("ping pulse");
    property p_dout;
        rx_stb |-> ##2 dout_pin == $past(rx_out_word[3:0], 2);
    endproperty
    a_dout: assert property (p_dout) else $error("outputs");
    property p_flt;
        tx_status_word[3] |-> !tx_status_word[10];
    endproperty
    a_flt: assert property (p_flt) else $error("fault bits");
    property p_alm;
        up_q |-> tx_status_word[7] != tx_status_word[9];
    endproperty
    a_alm: assert property (p_alm) else $error("alarm bits");
    property p_fixed;
        up_q |-> tx_status_word[11] && (tx_status_word & 16'hf077) == 16'h0;
    endproperty
    a_fixed: assert property (p_fixed) else $error("reserved");
    property p_diag;
        flt_evt && en_q && rt_q[0]
            |-> ##[2:10] (diag_a_one || flt_lost);
    endproperty
    a_diag: assert property (p_diag) else $error("no message");
    property p_shared;
        sh_q && rt_q[0] |-> !diag_a_two && !diag_b_two;
    endproperty
    a_shared: assert property (p_shared) else $error("shared");
    property p_term;
        up_q |-> term_out == (term_oe & dout_pin);
    endproperty
    a_term: assert property (p_term) else $error("terminals");
endmodule

bind cpw_central_words cpw_words_chk #(.W(W), .N(N)) u_chk (.*);

// ### sim/cpw_bus_ctl.sv
// fieldbus controller model: sends telegrams, logs diagnostics
// assumes the unit's core clock
`timescale 1ns/10ps

module cpw_bus_ctl (
    input logic core_clk,
    output logic rx_stb = 1'b0,
    output logic [15:0] rx_ctrl_word = 16'h0000,
    output logic [15:0] rx_out_word = 16'h0000,
    input logic diag_a_one,
    input logic diag_a_two,
    input logic [15:0] diag_a_data,
    input logic diag_b_one,
    input logic diag_b_two
);
    logic [15:0] msg_q[$];
    time stamp_q[$];
    int n_two;
    int n_b;

    // one telegram; words stand until the next strobe
    task send(input logic [15:0] c, input logic [15:0] o);
        @(posedge core_clk);
        rx_stb <= 1'b1;
        rx_ctrl_word <= c;
        rx_out_word <= o;
        @(posedge core_clk);
        rx_stb <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // stamp fault messages on arrival, count the rest
    always @(posedge core_clk) begin
        if (diag_a_one || diag_a_two) begin
            msg_q.push_back(diag_a_data);
            stamp_q.push_back($time);
        end
        if (diag_a_two || diag_b_two)
            n_two++;
        if (diag_b_one || diag_b_two)
            n_b++;
    end
endmodule

// ### sim/tb_top.sv
// top testbench for the central process words
// assumes the controller model and the bound checker
`timescale 1ns/10ps

module tb_top;
    logic core_clk, sys_rst, rx_stb, utc_set, obj_acked, time_sync_req;
    logic flt_evt, alm_evt, alm_gone, diag_en_cfg, class_mode_cfg;
    logic shared_cfg, diag_a_one, diag_a_two, diag_b_one, diag_b_two;
    logic flt_lost, alm_lost;
    logic [1:0] route_cfg;
    logic [3:0] din_pin, term_in, term_out, term_oe, term_dir_cfg, dout_pin;
    logic [15:0] rx_ctrl_word, rx_out_word, tx_status_word, tx_input_word;
    logic [15:0] flt_code, flt_class, alm_code, alm_class;
    logic [15:0] diag_a_data, diag_b_data;
    int error_cnt, total_checks, cyc, n_utc;

    cpw_central_words dut (.*);
    cpw_bus_ctl u_ctl (.*);

    // core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // hang guard and ping pulse count
    always @(posedge core_clk) begin
        cyc++;
        if (utc_set === 1'b1)
            n_utc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task cmp(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task cbit(input int i, input logic e);
        cmp(16'(tx_status_word[i]), 16'(e));
    endtask

    task wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one fault or alarm event, class is the inverted code
    task ev(input logic al, input logic [15:0] c);
        @(posedge core_clk);
        flt_evt <= !al;
        alm_evt <= al;
        {flt_code, alm_code} <= {c, c};
        {flt_class, alm_class} <= {~c, ~c};
        @(posedge core_clk);
        {flt_evt, alm_evt} <= 2'h0;
    endtask

    task do_reset(input logic sh);
        sys_rst <= 1'b1;
        shared_cfg <= sh;
        class_mode_cfg <= sh;
        diag_en_cfg <= 1'b1;
        wt(12);
        sys_rst <= 1'b0;
        wt(2);
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_words();
        u_ctl.send(16'h0000, 16'hfff5);
        wt(3);
        cmp(16'(dout_pin), 16'h0005);
        u_ctl.send(16'h0002, 16'h000a);
        u_ctl.send(16'h0002, 16'h0003);
        wt(4);
        cmp(16'(dout_pin), 16'h0003);
        cmp(16'(n_utc), 16'h0001);
    endtask

    task t_io();
        din_pin <= 4'h9;
        term_in <= 4'h6;
        term_dir_cfg <= 4'h5;
        time_sync_req <= 1'b1;
        wt(5);
        cmp(tx_input_word, 16'h0906);
        cmp(16'(term_out), 16'h0001);
        cmp(16'(term_oe), 16'h0005);
        cbit(8, 1'b1);
        time_sync_req <= 1'b0;
        wt(4);
        cbit(8, 1'b0);
    endtask

    // faults leave in order; local control clears on object acknowledge
    task t_fault();
        for (int i = 1; i < 4; i++)
            ev(1'b0, 16'(i * 17));
        wt(4);
        cbit(3, 1'b1);
        cbit(10, 1'b0);
        for (int i = 0; i < 3; i++)
            cmp(u_ctl.msg_q[i], 16'((i + 1) * 17));
        u_ctl.send(16'h0080, 16'h0003);
        wt(4);
        cbit(3, 1'b0);
        cbit(10, 1'b0);
        obj_acked <= 1'b1;
        wt(3);
        cbit(10, 1'b1);
    endtask

    // external control needs a second explicit acknowledge
    task t_xfer();
        obj_acked <= 1'b0;
        u_ctl.send(16'h0400, 16'h0003);
        ev(1'b0, 16'h0044);
        u_ctl.send(16'h0480, 16'h0003);
        wt(4);
        cbit(10, 1'b0);
        obj_acked <= 1'b1;
        wt(4);
        cbit(10, 1'b0);
        u_ctl.send(16'h0400, 16'h0003);
        u_ctl.send(16'h0480, 16'h0003);
        wt(4);
        cbit(10, 1'b1);
    endtask

    task t_alarm();
        for (int i = 1; i < 10; i++)
            ev(1'b1, 16'(i));
        wt(4);
        cmp(16'(alm_lost), 16'h0001);
        cmp(16'(u_ctl.n_b), 16'h0008);
        cmp(diag_b_data, 16'h0008);
        cbit(7, 1'b1);
        cbit(9, 1'b0);
        alm_gone <= 1'b1;
        wt(1);
        alm_gone <= 1'b0;
        wt(3);
        cbit(7, 1'b0);
        cbit(9, 1'b1);
    endtask

    // second power-up: shared mode, class reporting, enable held
    task t_share();
        cmp(16'(u_ctl.n_two), 16'h000c);
        do_reset(1'b1);
        diag_en_cfg <= 1'b0;
        class_mode_cfg <= 1'b0;
        ev(1'b0, 16'h0055);
        wt(4);
        cmp(16'(u_ctl.n_two), 16'h000c);
        cmp(16'(u_ctl.msg_q.size()), 16'h0005);
        cmp(diag_a_data, 16'hffaa);
        for (int i = 0; i < 8; i++)
            ev(1'b0, 16'(i));
        wt(2);
        cmp(16'(flt_lost), 16'h0001);
        u_ctl.send(16'h0080, 16'h0003);
        wt(3);
        cmp(16'(flt_lost), 16'h0000);
    endtask

    initial begin
        {flt_evt, alm_evt, alm_gone, obj_acked, time_sync_req} = 5'h00;
        {din_pin, term_in, term_dir_cfg} = 12'h000;
        {flt_code, flt_class, alm_code, alm_class} = 64'h0;
        route_cfg = 2'h3;
        do_reset(1'b0);
        t_words();
        t_io();
        t_fault();
        t_xfer();
        t_alarm();
        t_share();
        finish_test();
    end
endmodule
